// ### hw/ledpwm_pkg.sv
// constants and types of the serial led pwm driver
package ledpwm_pkg;
  localparam int CHANNELS = 16;
  localparam int BRIGHT_W = 12;
  localparam int TRIM_W = 6;
  localparam int BRIGHT_FRAME_W = 192;
  localparam int TRIM_FRAME_W = 96;
  localparam logic [11:0] BRIGHT_RESET = 12'hfff;
  localparam logic [5:0] TRIM_RESET = 6'h3f;
  localparam int CLOCK_HZ = 40000000;
  localparam int SAMPLE_DELAY_NS = 1000;
  localparam int SAMPLE_CYCLES = (SAMPLE_DELAY_NS * (CLOCK_HZ / 1000000)
    + 999) / 1000;
  localparam int FR_OPEN_HI = 176;
  localparam int FR_THERMAL = 175;
  localparam int FR_TRIM_LO = 72;
  localparam int FR_OPEN_LO = 16;
  localparam int FR_SHORT_LO = 0;
  typedef struct packed {
    logic serial_in;
    logic serial_clock;
    logic mode_select;
    logic latch_strobe;
    logic output_enable_low;
    logic pwm_count_clock;
  } ledpwm_pins_t;
  typedef struct packed {
    logic [15:0] open_led;
    logic [15:0] led_short;
    logic thermal_error;
  } ledpwm_sense_t;
endpackage : ledpwm_pkg

// ### hw/ledpwm_top.sv
// serial interface, latches, pwm and open-led detection of the driver
`timescale 1ns/100ps
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
module ledpwm_top
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // host pins and analog sense
  input wire ledpwm_pkg::ledpwm_pins_t pins,
  input wire ledpwm_pkg::ledpwm_sense_t sense,
  // outputs
  output logic serial_out,
  output logic [15:0] led_channel_output,
  output logic error_flag_low_o,
  output logic error_flag_low_oe,
  output logic [191:0] status_readback_frame
);
  import ledpwm_pkg::*;

  initial
  begin
    if (SAMPLE_CYCLES < 1)
    begin
      $error("sample delay must be at least one cycle");
    end
    if (SAMPLE_CYCLES > 63)
    begin
      $error("sample delay does not fit the wait counter");
    end
  end

  //--------------------------------------------------------------------
  // reset release and pin synchronisers
  //--------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;
  ledpwm_pins_t pin_s1_reg, pin_s2_reg, pin_d_reg;
  ledpwm_sense_t sen_s1_reg, sen_s2_reg;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_d_reg <= '0;
      sen_s1_reg <= '0;
      sen_s2_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
      sen_s1_reg <= sense;
      sen_s2_reg <= sen_s1_reg;
    end
  end

  logic sclk_rise, latch_rise, pwm_rise, oe_fall, oe_high, mode;
  assign sclk_rise = pin_s2_reg.serial_clock & ~pin_d_reg.serial_clock;
  assign latch_rise = pin_s2_reg.latch_strobe & ~pin_d_reg.latch_strobe;
  assign pwm_rise = pin_s2_reg.pwm_count_clock & ~pin_d_reg.pwm_count_clock;
  assign oe_high = pin_s2_reg.output_enable_low;
  assign oe_fall = ~oe_high & pin_d_reg.output_enable_low;
  assign mode = pin_s2_reg.mode_select;

  //--------------------------------------------------------------------
  // shift register, latches and status frame
  //--------------------------------------------------------------------
  logic [191:0] shift_reg, shift_next;
  logic [191:0] bright_reg, bright_next;
  logic [95:0] trim_reg, trim_next;
  logic [191:0] frame;
  logic [15:0] open_reg, open_next;
  logic out_reg, out_next;

  always_comb
  begin
    frame = '0;
    frame[FR_OPEN_HI +: 16] = open_reg;
    frame[FR_THERMAL] = sen_s2_reg.thermal_error;
    frame[FR_TRIM_LO +: 96] = trim_reg;
    frame[FR_OPEN_LO +: 16] = open_reg;
    frame[FR_SHORT_LO +: 16] = sen_s2_reg.led_short;
  end

  always_comb
  begin
    shift_next = shift_reg;
    bright_next = bright_reg;
    trim_next = trim_reg;
    out_next = out_reg;
    if (sclk_rise)
    begin
      if (mode)
      begin
        shift_next = {96'h0, shift_reg[94:0], pins_in_bit()};
        out_next = shift_reg[TRIM_FRAME_W - 1];
      end
      else
      begin
        shift_next = {shift_reg[190:0], pins_in_bit()};
        out_next = shift_reg[BRIGHT_FRAME_W - 1];
      end
    end
    if (latch_rise)
    begin
      if (mode)
      begin
        trim_next = shift_reg[95:0];
      end
      else
      begin
        bright_next = shift_reg;
        shift_next = frame;
      end
    end
  end

  function automatic logic pins_in_bit();
    pins_in_bit = pin_s2_reg.serial_in;
  endfunction : pins_in_bit

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_reg <= '0;
      bright_reg <= {CHANNELS{BRIGHT_RESET}};
      trim_reg <= {CHANNELS{TRIM_RESET}};
      out_reg <= 1'b0;
    end
    else
    begin
      shift_reg <= shift_next;
      bright_reg <= bright_next;
      trim_reg <= trim_next;
      out_reg <= out_next;
    end
  end

  //--------------------------------------------------------------------
  // pwm counter and channel outputs
  //--------------------------------------------------------------------
  logic [12:0] cnt_reg, cnt_next;
  logic run_reg, run_next;
  logic [15:0] on_reg, on_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    on_next = on_reg;
    if (oe_high)
    begin
      cnt_next = '0;
      run_next = 1'b0;
      on_next = '0;
    end
    else
    begin
      if (oe_fall)
      begin
        run_next = 1'b1;
        cnt_next = '0;
      end
      else if (run_reg && pwm_rise && cnt_reg < 13'h1000)
      begin
        cnt_next = cnt_reg + 13'h1;
        for (int i = 0; i < CHANNELS; i++)
        begin
          if (cnt_reg == 13'h0)
          begin
            on_next[i] = bright_reg[i*12 +: 12] != 12'h0;
          end
          // off one interval after reaching the value: v/4096 on-time
          else if (cnt_reg[11:0] == bright_reg[i*12 +: 12] ||
                   cnt_next[12])
          begin
            on_next[i] = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      on_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      on_reg <= on_next;
    end
  end

  //--------------------------------------------------------------------
  // open-led detection
  //--------------------------------------------------------------------
  logic [15:0] on_d_reg;
  logic [5:0] wait_reg [16];
  logic [5:0] wait_next [16];

  always_comb
  begin
    open_next = open_reg;
    for (int i = 0; i < CHANNELS; i++)
    begin
      wait_next[i] = wait_reg[i];
      if (!on_reg[i])
      begin
        wait_next[i] = '0;
      end
      else if (on_reg[i] && !on_d_reg[i])
      begin
        wait_next[i] = 6'(SAMPLE_CYCLES);
      end
      else if (wait_reg[i] != 6'h0)
      begin
        wait_next[i] = wait_reg[i] - 6'h1;
        if (wait_reg[i] == 6'h1 && !oe_high)
        begin
          open_next[i] = sen_s2_reg.open_led[i];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      open_reg <= '0;
      on_d_reg <= '0;
      for (int i = 0; i < CHANNELS; i++)
      begin
        wait_reg[i] <= '0;
      end
    end
    else
    begin
      open_reg <= open_next;
      on_d_reg <= on_reg;
      wait_reg <= wait_next;
    end
  end

  //--------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------
  assign serial_out = out_reg;
  assign led_channel_output = on_reg & {16{~oe_high}};
  assign error_flag_low_o = 1'b0;
  assign error_flag_low_oe = sen_s2_reg.thermal_error |
    (|open_reg & ~oe_high);
  assign status_readback_frame = frame;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  oe_disables_a: assert property (@(posedge clock) disable iff (!rst_n)
    oe_high |=> on_reg == 16'h0)
    else $error("channel on while disabled");
  oe_counter_a: assert property (@(posedge clock) disable iff (!rst_n)
    oe_high |=> cnt_reg == 13'h0)
    else $error("counter not held in reset");
  bright_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
    latch_rise && !mode |=> bright_reg == $past(shift_reg))
    else $error("brightness latch wrong");
  trim_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
    latch_rise && mode |=> trim_reg == $past(shift_reg[95:0]))
    else $error("trim latch wrong");
  frame_load_a: assert property (@(posedge clock) disable iff (!rst_n)
    latch_rise && !mode |=> shift_reg == $past(frame))
    else $error("status frame not loaded");
  err_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|open_reg && !oe_high) |-> error_flag_low_oe)
    else $error("error flag not pulled");
  frame_dup_a: assert property (@(posedge clock) disable iff (!rst_n)
    frame[191:176] == frame[31:16] && frame[171:168] == 4'h0)
    else $error("open bits mismatch");
  shift_in_a: assert property (@(posedge clock) disable iff (!rst_n)
    sclk_rise && !latch_rise |=> shift_reg[0] == $past(pin_s2_reg.serial_in))
    else $error("bit not shifted");
  cnt_limit_a: assert property (@(posedge clock) disable iff (!rst_n)
    cnt_reg <= 13'h1000)
    else $error("pwm counter beyond cycle end");
  first_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    run_reg && pwm_rise && !oe_high && !oe_fall && cnt_reg == 13'h0
      |=> cnt_reg == 13'h1)
    else $error("first pulse did not count");
  err_release_a: assert property (@(posedge clock) disable iff (!rst_n)
    !sen_s2_reg.thermal_error && (oe_high || open_reg == 16'h0) |->
      !error_flag_low_oe)
    else $error("error flag pulled without error");
  open_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    oe_high |=> $stable(open_reg))
    else $error("open flag sampled while disabled");
  trim_width_a: assert property (@(posedge clock) disable iff (!rst_n)
    sclk_rise && mode |=> shift_reg[191:96] == 96'h0)
    else $error("trim shift wider than 96 bits");
  out_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    sclk_rise && !mode |=> serial_out == $past(shift_reg[191]))
    else $error("serial output bit wrong");
endmodule : ledpwm_top

// ### tb/ledpwm_host.sv
// host model driving the serial and enable pins
`timescale 1ns/100ps
module ledpwm_host
  import ledpwm_pkg::*;
(
  // clock
  input wire logic clock,
  // driver pins
  output ledpwm_pkg::ledpwm_pins_t pins,
  input wire logic serial_out
);
  logic [191:0] seen;
  // ----
  // pin drivers
  // ----
  initial pins = 6'h02;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // shift n bits msb first, 200 ns period, capture outgoing bits
  task automatic send(input logic [191:0] d, input int n, input logic m);
    pins.mode_select <= m;
    tick(8);
    for (int i = n - 1; i >= 0; i--)
    begin
      pins.serial_in <= d[i];
      pins.serial_clock <= 1'b0;
      tick(4);
      if (i < n - 1)
        seen[i + 1] = serial_out;
      pins.serial_clock <= 1'b1;
      tick(4);
    end
    pins.serial_clock <= 1'b0;
    pins.serial_in <= ~pins.serial_in;
    tick(4);
    seen[0] = serial_out;
  endtask : send
  task automatic latch;
    pins.latch_strobe <= 1'b1;
    tick(4);
    pins.latch_strobe <= 1'b0;
    tick(8);
  endtask : latch
  task automatic pulse;
    pins.pwm_count_clock <= 1'b1;
    tick(4);
    pins.pwm_count_clock <= 1'b0;
    tick(4);
  endtask : pulse
  task automatic enable(input logic v);
    pins.output_enable_low <= v;
    tick(8);
  endtask : enable
endmodule : ledpwm_host

// ### tb/ledpwm_tb.sv
// self-checking bench of the serial led pwm driver
`timescale 1ns/100ps
module ledpwm_tb;
  import ledpwm_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  ledpwm_sense_t sense = '0;
  ledpwm_pins_t pins;
  logic serial_out, error_flag_low_o, error_flag_low_oe;
  logic [15:0] led_channel_output;
  logic [191:0] status_readback_frame, trim, bright;
  int error_cnt = 0;
  int compares = 0;
  always #12.5 clock = ~clock;
  ledpwm_top DUT (.clock(clock), .reset_n(reset_n), .pins(pins),
    .sense(sense), .serial_out(serial_out),
    .led_channel_output(led_channel_output),
    .error_flag_low_o(error_flag_low_o),
    .error_flag_low_oe(error_flag_low_oe),
    .status_readback_frame(status_readback_frame));
  ledpwm_host host (.clock(clock), .pins(pins), .serial_out(serial_out));
  // ----
  // checking
  // ----
  task automatic check(input string nm, input logic [191:0] s,
    input logic [191:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  function automatic logic [191:0] frame(input logic [15:0] op,
    input logic th, input logic [95:0] tr, input logic [15:0] sh);
    frame = '0;
    frame[191:176] = op;
    frame[175] = th;
    frame[167:72] = tr;
    frame[31:16] = op;
    frame[15:0] = sh;
  endfunction : frame
  task automatic print_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // ----
  // scenarios
  // ----
  task automatic t_defaults;
    check("frame", status_readback_frame, frame(0, 0, {16{6'h3f}}, 0));
    check("leds", led_channel_output, 0);
    check("flag_o", error_flag_low_o, 0);
    check("flag_oe", error_flag_low_oe, 0);
  endtask : t_defaults
  task automatic t_trim;
    host.send(trim, 96, 1'b1);
    check("out_cleared", host.seen[95:0], 0);
    host.latch();
    check("trim_field", status_readback_frame[167:72], trim[95:0]);
  endtask : t_trim
  task automatic t_pwm;
    sense.open_led <= 16'h0004;
    host.send(bright, 192, 1'b0);
    host.latch();
    host.enable(1'b0);
    host.pulse();
    check("on_first", led_channel_output, 16'hfffd);
    host.pulse();
    host.pulse();
    check("on_at_value", led_channel_output, 16'hfffd);
    host.pulse();
    check("off_at_value", led_channel_output, 16'hfffc);
    check("no_early_sample", error_flag_low_oe, 0);
    host.tick(30);
    check("open_flag", error_flag_low_oe, 1);
  endtask : t_pwm
  task automatic t_readback;
    logic [191:0] exp;
    sense.led_short <= 16'ha5c3;
    host.send(bright, 192, 1'b0);
    host.latch();
    exp = frame(16'h0004, 1'b0, trim[95:0], 16'ha5c3);
    check("frame_view", status_readback_frame, exp);
    host.send(bright, 192, 1'b0);
    check("frame_out", host.seen, exp);
  endtask : t_readback
  task automatic t_enable;
    host.enable(1'b1);
    check("disabled", led_channel_output, 0);
    check("open_masked", error_flag_low_oe, 0);
    sense.thermal_error <= 1'b1;
    host.tick(8);
    check("thermal_flag", error_flag_low_oe, 1);
    check("thermal_bit", status_readback_frame[175], 1);
    sense.thermal_error <= 1'b0;
    sense.open_led <= 16'h0000;
    host.tick(8);
    check("flag_released", error_flag_low_oe, 0);
    host.enable(1'b0);
    check("open_held", error_flag_low_oe, 1);
    repeat (3) host.pulse();
    check("counter_reset", led_channel_output, 16'hfffd);
    host.pulse();
    check("off_again", led_channel_output, 16'hfffc);
    host.tick(20);
    check("open_cleared", error_flag_low_oe, 0);
    check("open_bits", status_readback_frame[191:176], 0);
  endtask : t_enable
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    trim = '0;
    for (int i = 0; i < 16; i++)
      trim[6 * i +: 6] = 6'(i);
    bright = {{14{12'hfff}}, 12'h000, 12'h003};
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    host.tick(6);
    t_defaults();
    t_trim();
    t_pwm();
    t_readback();
    t_enable();
    print_verdict();
  end
endmodule : ledpwm_tb
